//--- rtl/dac_ctrl_regs.svh
`ifndef DAC_CTRL_REGS_SVH
`define DAC_CTRL_REGS_SVH
// ----------------------------------------------------------------------
// instruction word layout
// ----------------------------------------------------------------------
`define WORD_W        24
`define NCH           16
`define F_CMD_LSB     20
`define F_CH_LSB      16
// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CMD_WR_N      4'h0
`define CMD_WR_ALL    4'h8
`define CMD_RNG_N     4'h6
`define CMD_RNG_ALL   4'hE
`define CMD_UPD_N     4'h1
`define CMD_UPD_ALL   4'h9
`define CMD_WRN_UPDN  4'h3
`define CMD_WRN_UPDA  4'h2
`define CMD_WRA_UPDA  4'hA
`define CMD_PD_N      4'h4
`define CMD_PD_CHIP   4'h5
`define CMD_MUX       4'hB
`define CMD_TSEL      4'hC
`define CMD_GTOG      4'hD
`define CMD_CONFIG    4'h7
`define CMD_NOP       4'hF
// ----------------------------------------------------------------------
// range codes, reset codes, straps
// ----------------------------------------------------------------------
`define RANGE_0_5     3'h0
`define RANGE_0_10    3'h1
`define RANGE_PM5     3'h2
`define RANGE_PM10    3'h3
`define RANGE_PM2P5   3'h4
`define CODE_ZERO     16'h0000
`define CODE_MID      16'h8000
`define STRAP_SOFT    3'h7
// ----------------------------------------------------------------------
// pin sampling: sclk,sdi,strobe,update,toggle,clear,strap[2:0]
// ----------------------------------------------------------------------
`define PIN_W         9
`define PIN_IDLE      9'h02C
`define INIT_CYC      2'h3
// ----------------------------------------------------------------------
// host command port and link timing
// ----------------------------------------------------------------------
`define H_WORD        4'h0
`define H_CTRL        4'h1
`define H_PINS        4'h2
`define H_STAT        4'h3
`define SYS_CLK_NS    50
`define SCLK_HALF_NS  200
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define LU_PULSE_NS   400
`define LU_PULSE_CYC  ((`LU_PULSE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`endif

//--- rtl/dac_ctrl_pkg.sv
`include "dac_ctrl_regs.svh"
package dac_ctrl_pkg;
    typedef logic [15:0] code_t;
    typedef logic [2:0]  range_t;
    typedef logic [3:0]  cmd_t;
    typedef logic [3:0]  chan_t;
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_END, H_GAP} hstate_t;

    // strap decode: range held in fixed mode and after clear
    function automatic range_t strap_range(input logic [2:0] s);
        unique case (s)
            3'h0: strap_range = `RANGE_PM10;
            3'h1: strap_range = `RANGE_PM5;
            3'h2: strap_range = `RANGE_PM2P5;
            3'h3, 3'h4: strap_range = `RANGE_0_10;
            default: strap_range = `RANGE_0_5;
        endcase
    endfunction

    // strap decode: reset code, mid or zero scale
    function automatic code_t strap_code(input logic [2:0] s);
        unique case (s)
            3'h3, 3'h5, 3'h7: strap_code = `CODE_ZERO;
            default: strap_code = `CODE_MID;
        endcase
    endfunction
endpackage

//--- rtl/dac_link_if.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// serial link and control pins between host and converter
// ----------------------------------------------------------------------
interface dac_link_if;
    logic sclk;        // serial clock, made by host
    logic sdi;         // serial data, host to converter
    logic selLoadN;    // select/load strobe, low during a word
    logic loadUpdateN; // low pulse updates all channels
    logic togglePin;   // external toggle level
    logic clearN;      // clear, low active level
    modport ctrl (output sclk, sdi, selLoadN, loadUpdateN, togglePin,
                  clearN);
    modport dac (input sclk, sdi, selLoadN, loadUpdateN, togglePin,
                 clearN);
endinterface

//--- rtl/pin_sync.sv
`timescale 1ns/10ps
`include "dac_ctrl_regs.svh"
// ----------------------------------------------------------------------
// two-stage synchroniser with edge detection on the second stage
// ----------------------------------------------------------------------
module pin_sync (
    input  wire logic              sys_clk, // system clock
    input  wire logic              rst,     // async reset, high
    input  wire logic [`PIN_W-1:0] pins,    // raw pins
    output logic      [`PIN_W-1:0] lvl,     // synchronised level
    output logic      [`PIN_W-1:0] rise,    // one-cycle rising edge
    output logic      [`PIN_W-1:0] fall     // one-cycle falling edge
);
    logic [`PIN_W-1:0] s1_r;
    logic [`PIN_W-1:0] s2_r;
    logic [`PIN_W-1:0] s3_r;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_r <= `PIN_IDLE;
            s2_r <= `PIN_IDLE;
            s3_r <= `PIN_IDLE;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // edges between settled samples
    assign lvl  = s2_r;
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
endmodule // pin_sync

//--- rtl/dac_core.sv
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "dac_ctrl_regs.svh"
//
// Contract
// - capture data on sclk rise while strobe low
// - order is command, channel, then data
// - code MSB first; 12-bit adds four pad bits
// - strobe rise ends word and executes it
// - 32-bit word: eight ignored leading bits
// - host uses 32-bit words for echo/chains
// - code is unsigned straight binary always
// - double-buffered code and range per channel
// - input A default, B only for toggle
// - update copies input and powers channel up
// - update reloads code and range together
// - update by command, update pin, toggle
// - range codes 0..4 decode five output ranges
// - 0110/1110 write range input, one or all
// - straps all high: programmable, zero 0-5V
// - straps select fixed range and reset code
// - monitor disabled from power-up until enabled
// - monitor field: zero off, top bit routes
// - command field decodes the full command set
// - toggle select steers code writes to B
// - clear low restores strap state, zeros control
//
module dac_core
    import dac_ctrl_pkg::*;
(
    input  wire logic       sys_clk,             // system clock
    input  wire logic       rst,                 // async reset, high
    dac_link_if.dac         link,                // serial link pins
    input  wire logic [2:0] rangeStrapPins,      // range straps
    output code_t           dacCode [`NCH],      // output code
    output range_t          dacRange [`NCH],     // output range
    output logic [`NCH-1:0] powerDown,           // channel powered down
    output logic            chipDown,            // chip powered down
    output logic            monitorEn,           // monitor driven
    output chan_t           monitorChan,         // monitored channel
    output logic [3:0]      cfgBits,             // configuration field
    output logic            softMode             // programmable range
);
    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    logic [`PIN_W-1:0] pinLvl;
    logic [`PIN_W-1:0] pinRise;
    logic [`PIN_W-1:0] pinFall;

    pin_sync u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pins    ({rangeStrapPins, link.clearN, link.togglePin,
                   link.loadUpdateN, link.selLoadN, link.sdi,
                   link.sclk}),
        .lvl     (pinLvl),
        .rise    (pinRise),
        .fall    (pinFall)
    );

    logic [2:0] strap;
    logic       sclkRise;
    logic       strobeLow;
    logic       exec;
    logic       luFall;
    logic       toggleLvl;
    assign strap     = pinLvl[8:6];
    assign sclkRise  = pinRise[0];
    assign strobeLow = ~pinLvl[2];
    assign exec      = pinRise[2];
    assign luFall    = pinFall[3];
    assign toggleLvl = pinLvl[4];

    // ------------------------------------------------------------------
    // shift register and field split
    // ------------------------------------------------------------------
    logic [`WORD_W-1:0] shift_r;
    logic [1:0]         initCnt_r;
    logic               clr;
    cmd_t               cmd;
    chan_t              chSel;
    code_t              data;
    // leading bits of a long word fall off the top
    assign cmd   = shift_r[`WORD_W-1:`F_CMD_LSB];
    assign chSel = shift_r[`F_CMD_LSB-1:`F_CH_LSB];
    assign data  = shift_r[`F_CH_LSB-1:0];
    assign clr   = (initCnt_r != `INIT_CYC) | ~pinLvl[5];

    // shift only while the strobe is low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_r <= '0;
        end else if (sclkRise && strobeLow) begin
            shift_r <= {shift_r[`WORD_W-2:0], pinLvl[1]};
        end
    end

    // hold the clear until the straps have been sampled
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            initCnt_r <= '0;
        end else if (initCnt_r != `INIT_CYC) begin
            initCnt_r <= initCnt_r + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    logic wrCodeAll;
    logic wrCodeN;
    logic wrRngAll;
    logic wrRngN;
    logic updAll;
    logic updN;
    logic pdChip;
    logic pdN;
    assign wrCodeAll = (cmd == `CMD_WR_ALL) | (cmd == `CMD_WRA_UPDA);
    assign wrCodeN   = (cmd == `CMD_WR_N) | (cmd == `CMD_WRN_UPDN) |
                       (cmd == `CMD_WRN_UPDA);
    assign wrRngAll  = (cmd == `CMD_RNG_ALL);
    assign wrRngN    = (cmd == `CMD_RNG_N);
    assign updAll    = (cmd == `CMD_UPD_ALL) | (cmd == `CMD_WRN_UPDA) |
                       (cmd == `CMD_WRA_UPDA);
    assign updN      = (cmd == `CMD_UPD_N) | (cmd == `CMD_WRN_UPDN);
    assign pdChip    = (cmd == `CMD_PD_CHIP);
    assign pdN       = (cmd == `CMD_PD_N);
    assign softMode  = (strap == `STRAP_SOFT);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [`NCH-1:0] toggleSel_r;
    logic            tgb_r;
    logic            tglLvl_r;
    logic [4:0]      muxSel_r;
    logic [3:0]      cfg_r;
    logic            chipDown_r;
    logic            tglNow;
    logic            tglEvt;
    logic            anyUpd;
    // toggle follows the combined level of global bit and pin
    assign tglNow = tgb_r & toggleLvl;
    assign tglEvt = (tglNow != tglLvl_r) & ~clr;
    assign anyUpd = exec & (updAll | updN);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            toggleSel_r <= '0;
            tgb_r       <= 1'b0;
            tglLvl_r    <= 1'b0;
            muxSel_r    <= '0;
            cfg_r       <= '0;
            chipDown_r  <= 1'b0;
        end else if (clr) begin
            toggleSel_r <= '0;
            tgb_r       <= 1'b0;
            tglLvl_r    <= 1'b0;
            muxSel_r    <= '0;
            cfg_r       <= '0;
            chipDown_r  <= 1'b0;
        end else begin
            tglLvl_r <= tglNow;
            if (exec && cmd == `CMD_TSEL) toggleSel_r <= data;
            if (exec && cmd == `CMD_GTOG) tgb_r <= data[0];
            if (exec && cmd == `CMD_MUX) muxSel_r <= data[4:0];
            if (exec && cmd == `CMD_CONFIG) cfg_r <= data[3:0];
            if (exec && pdChip) chipDown_r <= 1'b1;
            else if (anyUpd || luFall) chipDown_r <= 1'b0;
        end
    end

    // monitor routes only with the enable bit set
    assign monitorEn   = muxSel_r[4];
    assign monitorChan = muxSel_r[3:0];
    assign cfgBits     = cfg_r;
    assign chipDown    = chipDown_r;

    // ------------------------------------------------------------------
    // per-channel double buffers
    // ------------------------------------------------------------------
    code_t           codeA_r [`NCH];
    code_t           codeB_r [`NCH];
    range_t          rngIn_r [`NCH];
    code_t           dac_r [`NCH];
    range_t          dacRng_r [`NCH];
    logic [`NCH-1:0] pd_r;
    code_t           aNxt [`NCH];
    code_t           bNxt [`NCH];
    range_t          rNxt [`NCH];
    code_t           dacNxt [`NCH];
    range_t          dacRngNxt [`NCH];
    logic [`NCH-1:0] pdNxt;
    code_t           rstCode;
    range_t          rstRange;
    assign rstCode  = strap_code(strap);
    assign rstRange = strap_range(strap);

    for (genvar i = 0; i < `NCH; i++) begin : g_ch
        logic hit;
        logic wrC;
        logic wrR;
        logic upd;
        logic useB;
        assign hit  = (chSel == chan_t'(i));
        assign wrC  = exec & (wrCodeAll | (wrCodeN & hit));
        assign wrR  = exec & softMode & (wrRngAll | (wrRngN & hit));
        assign upd  = (exec & (updAll | (updN & hit))) | luFall |
                      (tglEvt & toggleSel_r[i]);
        assign useB = toggleSel_r[i] & tglNow;
        // writes land in input stages only
        assign aNxt[i] = clr ? rstCode :
                         (wrC & ~toggleSel_r[i]) ? data : codeA_r[i];
        assign bNxt[i] = clr ? rstCode :
                         (wrC & toggleSel_r[i]) ? data : codeB_r[i];
        assign rNxt[i] = clr ? rstRange : wrR ? range_t'(data[2:0]) :
                         rngIn_r[i];
        // update moves code and range as one
        assign dacNxt[i] = clr ? rstCode : upd ? (useB ? bNxt[i] : aNxt[i])
                         : dac_r[i];
        assign dacRngNxt[i] = clr ? rstRange : upd ? rNxt[i]
                            : dacRng_r[i];
        // a power-down command in the cycle of an update still wins
        assign pdNxt[i] = ~clr & ((pd_r[i] & ~upd) |
                          (exec & (pdChip | (pdN & hit))));
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `NCH; i++) begin
                codeA_r[i]  <= `CODE_ZERO;
                codeB_r[i]  <= `CODE_ZERO;
                rngIn_r[i]  <= `RANGE_0_5;
                dac_r[i]    <= `CODE_ZERO;
                dacRng_r[i] <= `RANGE_0_5;
            end
            pd_r <= '0;
        end else begin
            for (int i = 0; i < `NCH; i++) begin
                codeA_r[i]  <= aNxt[i];
                codeB_r[i]  <= bNxt[i];
                rngIn_r[i]  <= rNxt[i];
                dac_r[i]    <= dacNxt[i];
                dacRng_r[i] <= dacRngNxt[i];
            end
            pd_r <= pdNxt;
        end
    end

    assign dacCode   = dac_r;
    assign dacRange  = dacRng_r;
    assign powerDown = pd_r;
endmodule // dac_core

//--- rtl/dac_host.sv
`timescale 1ns/10ps
`include "dac_ctrl_regs.svh"
// ----------------------------------------------------------------------
// serial master: shifts 24- or 32-bit words out on command
// ----------------------------------------------------------------------
module dac_host
    import dac_ctrl_pkg::*;
(
    input  wire logic        sys_clk, // system clock
    input  wire logic        rst,     // async reset, high
    input  wire logic [3:0]  addr,    // register address
    input  wire logic [31:0] wdata,   // write data
    input  wire logic        wrStb,   // write strobe
    input  wire logic        rdStb,   // read strobe
    output logic      [31:0] rdata,   // read data, next cycle
    dac_link_if.ctrl         link     // serial link pins
);
    hstate_t     st_r;
    logic [31:0] word_r;
    logic [5:0]  bitsLeft_r;
    logic [2:0]  cnt_r;
    logic [3:0]  luCnt_r;
    logic        sclk_r;
    logic        sdi_r;
    logic        sel_r;
    logic        tgl_r;
    logic        clrAct_r;
    logic [31:0] rdata_r;
    logic        halfDone;
    logic        busy;
    logic        start;

    // ------------------------------------------------------------------
    // command port decode
    // ------------------------------------------------------------------
    assign halfDone = (cnt_r == 3'(`SCLK_HALF_CYC - 1));
    assign busy     = (st_r != H_IDLE);
    assign start    = wrStb && addr == `H_CTRL && wdata[0] && !busy;

    // read data stands one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (rdStb) begin
            unique case (addr)
                `H_WORD: rdata_r <= word_r;
                `H_PINS: rdata_r <= {29'h0, clrAct_r, tgl_r, luCnt_r != 4'h0};
                `H_STAT: rdata_r <= {31'h0, busy};
                default: rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    // pin levels and update pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            luCnt_r  <= '0;
            tgl_r    <= 1'b0;
            clrAct_r <= 1'b0;
        end else if (wrStb && addr == `H_PINS) begin
            if (wdata[0]) luCnt_r <= 4'(`LU_PULSE_CYC);
            tgl_r    <= wdata[1];
            clrAct_r <= wdata[2];
        end else if (luCnt_r != 4'h0) begin
            luCnt_r <= luCnt_r - 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // bit sequencer: data changes on falling sclk, taken on rising
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r       <= H_IDLE;
            word_r     <= '0;
            bitsLeft_r <= '0;
            cnt_r      <= '0;
            sclk_r     <= 1'b0;
            sdi_r      <= 1'b0;
            sel_r      <= 1'b1;
        end else begin
            cnt_r <= halfDone ? 3'h0 : cnt_r + 3'h1;
            unique case (st_r)
                H_IDLE: begin
                    cnt_r <= '0;
                    if (wrStb && addr == `H_WORD) word_r <= wdata;
                    if (start) begin
                        // long word: eight pad bits lead
                        bitsLeft_r <= wdata[1] ? 6'h20 : 6'h18;
                        if (!wdata[1]) word_r <= {word_r[23:0], 8'h00};
                        sdi_r <= wdata[1] ? word_r[31] : word_r[23];
                        sel_r <= 1'b0;
                        st_r  <= H_LOW;
                    end
                end
                H_LOW: if (halfDone) begin
                    sclk_r <= 1'b1;
                    st_r   <= H_HIGH;
                end
                H_HIGH: if (halfDone) begin
                    sclk_r     <= 1'b0;
                    bitsLeft_r <= bitsLeft_r - 6'h01;
                    word_r     <= {word_r[30:0], 1'b0};
                    sdi_r      <= word_r[30];
                    st_r       <= (bitsLeft_r == 6'h01) ? H_END : H_LOW;
                end
                H_END: if (halfDone) begin
                    sel_r <= 1'b1;
                    st_r  <= H_GAP;
                end
                H_GAP: if (halfDone) begin
                    st_r <= H_IDLE;
                end
            endcase
        end
    end

    assign rdata            = rdata_r;
    assign link.sclk        = sclk_r;
    assign link.sdi         = sdi_r;
    assign link.selLoadN    = sel_r;
    assign link.loadUpdateN = (luCnt_r == 4'h0);
    assign link.togglePin   = tgl_r;
    assign link.clearN      = ~clrAct_r;
endmodule // dac_host

//--- verification/dac_link_sva.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// serial link protocol checks
// ----------------------------------------------------------------------
module dac_link_sva (
    input wire logic sys_clk,     // system clock
    input wire logic rst,         // async reset, high
    input wire logic sclk,        // serial clock
    input wire logic sdi,         // serial data
    input wire logic selLoadN,    // select/load strobe
    input wire logic loadUpdateN, // update pin
    input wire logic togglePin,   // toggle level
    input wire logic clearN       // clear level
);
    logic [5:0] bitCnt_r; // serial clock rises in this word
    logic       sclkQ_r;  // serial clock one cycle back
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // count serial clock rises while the strobe is low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bitCnt_r <= 6'h00;
            sclkQ_r  <= 1'b0;
        end else begin
            sclkQ_r  <= sclk;
            if (selLoadN) bitCnt_r <= 6'h00;
            else if (sclk && !sclkQ_r) bitCnt_r <= bitCnt_r + 6'h01;
        end
    end
    sclk_idle_a: assert property (selLoadN |-> !sclk)
        else $error("serial clock high outside a word");
    sdi_hold_a: assert property ($rose(sclk) |-> $stable(sdi)[*4])
        else $error("serial data moved while clock high");
    sclk_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("serial clock high phase wrong");
    sclk_low_a: assert property ($fell(sclk) && !selLoadN |-> !sclk[*4])
        else $error("serial clock low phase short");
    first_bit_a: assert property ($fell(selLoadN) |-> !sclk[*3] ##[1:2] sclk)
        else $error("first bit not clocked in time");
    strobe_gap_a: assert property ($rose(selLoadN) |-> selLoadN[*3])
        else $error("strobe high gap too short");
    word_len_a: assert property ($rose(selLoadN) |->
        bitCnt_r == 6'h18 || bitCnt_r == 6'h20)
        else $error("word length not 24 or 32 bits");
    upd_pulse_a: assert property ($fell(loadUpdateN) |->
        !loadUpdateN[*8] ##1 loadUpdateN)
        else $error("update pulse length wrong");
endmodule // dac_link_sva

//--- verification/tb_multichannel_dac_serial_control.sv
`timescale 1ns/10ps
`include "dac_ctrl_regs.svh"
// ----------------------------------------------------------------------
// host port drives words over the link into the core
// ----------------------------------------------------------------------
module tb_multichannel_dac_serial_control import dac_ctrl_pkg::*;;
    logic sys_clk, rst, wrStb, rdStb, chipDown, monitorEn, softMode;
    logic [3:0]  addr, cfgBits;
    logic [31:0] wdata, rdata, rdV;
    logic [2:0]  straps;
    code_t       dacCode [`NCH];
    range_t      dacRange [`NCH];
    logic [`NCH-1:0] powerDown;
    chan_t       monitorChan;
    int          n_errors, checks_done;
    code_t       expC [7] = '{16'h8000, 16'h8000, 16'h8000, 16'h0000,
                              16'h8000, 16'h0000, 16'h8000};
    range_t      expR [7] = '{3'h3, 3'h2, 3'h4, 3'h1, 3'h1, 3'h0, 3'h0};
    dac_link_if link();
    dac_host dac_host_i (.sys_clk(sys_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
        .link(link));
    dac_core dac_core_i (.sys_clk(sys_clk), .rst(rst), .link(link),
        .rangeStrapPins(straps), .dacCode(dacCode), .dacRange(dacRange),
        .powerDown(powerDown), .chipDown(chipDown), .monitorEn(monitorEn),
        .monitorChan(monitorChan), .cfgBits(cfgBits), .softMode(softMode));
    dac_link_sva dac_link_sva_i (.sys_clk(sys_clk), .rst(rst),
        .sclk(link.sclk), .sdi(link.sdi), .selLoadN(link.selLoadN),
        .loadUpdateN(link.loadUpdateN), .togglePin(link.togglePin),
        .clearN(link.clearN));
    // clock
    always #25 sys_clk = ~sys_clk;
    // access and compare tasks
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a; wdata <= d; wrStb <= 1'b1;
        @(posedge sys_clk);
        wrStb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        addr <= a; rdStb <= 1'b1;
        @(posedge sys_clk);
        rdStb <= 1'b0;
        #1 rdV = rdata;
    endtask
    task automatic send(input logic lng, cmd_t c, chan_t ch, code_t d);
        int i;
        wr(4'h0, {8'hA5, c, ch, d});
        wr(4'h1, {30'h0, lng, 1'b1});
        rd(4'h3);
        for (i = 0; i < 300 && rdV[0] === 1'b1; i++) rd(4'h3);
        cmp(16'(rdV[0]), 16'h0000);
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic pins(input logic [2:0] p);
        wr(4'h2, {29'h0, p});
        repeat (20) @(posedge sys_clk);
    endtask
    task automatic allChk(input code_t c, input range_t r);
        for (int i = 0; i < `NCH; i++) begin
            cmp(dacCode[i], c);
            cmp(16'(dacRange[i]), 16'(r));
        end
    endtask
    task automatic doReset(input logic [2:0] s);
        straps <= s; rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic test_done;
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #2_000_000;
        n_errors++;
        test_done;
    end
    // main sequence
    initial begin
        sys_clk = 0; addr = 0; wdata = 0; wrStb = 0; rdStb = 0;
        n_errors = 0; checks_done = 0; rst = 1; straps = 3'h7;
        doReset(3'h7);
        allChk(16'h0000, 3'h0);
        cmp(16'(softMode), 16'h0001);
        cmp(16'(monitorEn), 16'h0000);
        send(1, `CMD_WR_N, 4'h5, 16'hA5C3);
        cmp(dacCode[5], 16'h0000);
        send(0, `CMD_UPD_N, 4'h5, 16'h0000);
        cmp(dacCode[5], 16'hA5C3);
        send(0, `CMD_RNG_N, 4'h5, 16'h0003);
        cmp(16'(dacRange[5]), 16'h0000);
        send(1, `CMD_UPD_N, 4'h5, 16'h0000);
        cmp(16'(dacRange[5]), 16'h0003);
        cmp(dacCode[5], 16'hA5C3);
        send(0, `CMD_RNG_ALL, 4'h0, 16'h0000);
        send(0, `CMD_WRA_UPDA, 4'h0, 16'h1234);
        allChk(16'h1234, 3'h0);
        send(0, `CMD_PD_N, 4'h2, 16'h0000);
        cmp(powerDown, 16'h0004);
        send(0, `CMD_PD_CHIP, 4'h0, 16'h0000);
        cmp(powerDown, 16'hFFFF);
        cmp(16'(chipDown), 16'h0001);
        send(0, `CMD_WRN_UPDN, 4'h1, 16'h5555);
        cmp(powerDown, 16'hFFFD);
        cmp(dacCode[1], 16'h5555);
        cmp(16'(chipDown), 16'h0000);
        pins(3'h1);
        cmp(powerDown, 16'h0000);
        send(0, `CMD_MUX, 4'h0, 16'h0013);
        cmp(16'({monitorEn, monitorChan}), 16'h0013);
        send(0, `CMD_MUX, 4'h0, 16'h0000);
        cmp(16'(monitorEn), 16'h0000);
        send(0, `CMD_TSEL, 4'h0, 16'h0020);
        send(0, `CMD_WR_N, 4'h5, 16'h0F0F);
        pins(3'h2);
        cmp(dacCode[5], 16'h1234);
        send(0, `CMD_GTOG, 4'h0, 16'h0001);
        cmp(dacCode[5], 16'h0F0F);
        pins(3'h0);
        cmp(dacCode[5], 16'h1234);
        send(0, `CMD_CONFIG, 4'h0, 16'h000A);
        cmp(16'(cfgBits), 16'h000A);
        send(0, `CMD_WR_ALL, 4'h0, 16'h2222);
        send(0, `CMD_WRN_UPDA, 4'h1, 16'h6666);
        send(0, `CMD_NOP, 4'h3, 16'h9999);
        cmp(dacCode[1], 16'h6666);
        cmp(dacCode[3], 16'h2222);
        cmp(dacCode[5], 16'h1234);
        pins(3'h4);
        pins(3'h0);
        allChk(16'h0000, 3'h0);
        cmp(16'(cfgBits), 16'h0000);
        rd(4'hF);
        cmp(rdV[15:0], 16'h0000);
        for (int s = 0; s < 7; s++) begin
            doReset(3'(s));
            allChk(expC[s], expR[s]);
            cmp(16'(softMode), 16'h0000);
        end
        send(0, `CMD_RNG_ALL, 4'h0, 16'h0003);
        send(0, `CMD_UPD_ALL, 4'h0, 16'h0000);
        allChk(16'h8000, 3'h0);
        test_done;
    end
endmodule // tb_multichannel_dac_serial_control
